/* logic/rca_regs.sv */
// Purpose: Per-channel adaptation and status register slice of a serial retimer.
// Assumes: Simple byte register port; read data is registered one cycle after the strobe.
// Notes: Loss flags clear on read; an event in the read cycle survives the clear.
`timescale 1ns/1ps
`default_nettype none
module rca_regs
    import rca_pkg::*;
#(
    parameter int BASE_CYCLES = BASE_INTERVAL_CYC,
    parameter int CNT_W = 15,
    parameter int DELTA_W = 4
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic signal_detect_i,
    input wire logic eq_limiting_i,
    input wire logic lock_irq_i,
    input wire logic sigdet_irq_i,
    input wire logic alt_view_i,
    input wire logic low_div_adapt_i,
    input wire logic lock_lost_i,
    input wire logic signal_lost_i,
    input wire logic tap1_sign_i,
    input wire logic [4:0] tap1_mag_i,
    input wire logic tap2_sign_i,
    input wire logic [3:0] tap2_mag_i,
    input wire logic [NUM_GROUPS-1:0][CNT_W-1:0] grp_builtin_count_i,
    input wire logic [NUM_GROUPS-1:0][DELTA_W-1:0] grp_builtin_delta_i,
    input wire logic lock_detectors_locked_i,
    input wire logic monitor_enable_i,
    input wire logic [7:0] horizontal_eye_opening_i,
    input wire logic [7:0] vertical_eye_opening_i,
    output logic [NUM_GROUPS-1:0][CNT_W-1:0] grp_count_o,
    output logic [NUM_GROUPS-1:0][DELTA_W-1:0] grp_delta_o,
    output logic [NUM_GROUPS-1:0] grp_override_o,
    output logic eye_sample_o,
    output logic [3:0] vert_lock_thr_o,
    output logic [3:0] horiz_lock_thr_o,
    output logic signed [19:0] adaptation_merit_o,
    output logic alt_merit_linear_o,
    output logic alt_merit_feedback_o,
    output logic [2:0] look_beyond_o
);
    // ============================================================
    // Storage
    logic [7:0] cnt_lo_r [NUM_GROUPS];
    logic [7:0] cnt_hi_r [NUM_GROUPS];
    logic [7:0] delta_r;
    logic [3:0] mon_int_r;
    logic [7:0] merit_a_r;
    logic [7:0] merit_b_r;
    logic [7:0] merit_c_r;
    logic [1:0] loss_r;
    logic [1:0] loss_nxt;
    logic [7:0] rdata_nxt;
    logic loss_rd;
    logic signed [19:0] merit_calc;
    logic mon_run;
    logic [17:0] base_cnt_r;
    logic [3:0] ivl_cnt_r;
    logic base_tick;

    localparam logic [7:0] GRP_LO_OFS [NUM_GROUPS] = '{OFS_G0_LO, OFS_G1_LO};
    localparam logic [7:0] GRP_HI_OFS [NUM_GROUPS] = '{OFS_G0_HI, OFS_G1_HI};

    // ============================================================
    // Frequency tolerance groups
    // One slice per group; override swaps built-in values for programmed ones
    for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grp
        logic [DELTA_W-1:0] prog_delta;
        // Group zero owns the upper delta nibble, group one the lower
        assign prog_delta = (g == 0) ? delta_r[7:4] : delta_r[3:0];

        // Count halves, both reset to zero
        always_ff @(posedge clk_i) begin
            if (reset_i) begin
                cnt_lo_r[g] <= RST_ZERO;
                cnt_hi_r[g] <= RST_ZERO;
            end else if (reg_wr_i) begin
                if (reg_addr_i == GRP_LO_OFS[g]) begin
                    cnt_lo_r[g] <= reg_wdata_i;
                end
                if (reg_addr_i == GRP_HI_OFS[g]) begin
                    cnt_hi_r[g] <= reg_wdata_i;
                end
            end
        end

        // Effective values presented to the recovery loop
        always_ff @(posedge clk_i) begin
            if (reset_i) begin
                grp_count_o[g] <= '0;
                grp_delta_o[g] <= '0;
                grp_override_o[g] <= 1'b0;
            end else begin
                grp_override_o[g] <= cnt_hi_r[g][BIT_OVERRIDE];
                if (cnt_hi_r[g][BIT_OVERRIDE]) begin
                    grp_count_o[g] <= {cnt_hi_r[g][6:0], cnt_lo_r[g]};
                    grp_delta_o[g] <= prog_delta;
                end else begin
                    grp_count_o[g] <= grp_builtin_count_i[g];
                    grp_delta_o[g] <= grp_builtin_delta_i[g];
                end
            end
        end
    end

    // ============================================================
    // Plain read/write configuration
    // Offsets for read-only registers have no write path at all
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            delta_r <= RST_ZERO;
            mon_int_r <= RST_MON_INT;
            vert_lock_thr_o <= RST_EYE_THR;
            horiz_lock_thr_o <= RST_EYE_THR;
            merit_a_r <= RST_MERIT_A;
            merit_b_r <= RST_ZERO;
            merit_c_r <= RST_ZERO;
            alt_merit_linear_o <= 1'b0;
            alt_merit_feedback_o <= 1'b0;
            look_beyond_o <= RST_LOOK;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                OFS_DELTA: begin
                    delta_r <= reg_wdata_i;
                end
                OFS_MON_INT: begin
                    mon_int_r <= reg_wdata_i[3:0];
                end
                OFS_EYE_THR: begin
                    vert_lock_thr_o <= reg_wdata_i[7:4];
                    horiz_lock_thr_o <= reg_wdata_i[3:0];
                end
                OFS_MERIT_A: begin
                    merit_a_r <= reg_wdata_i;
                end
                OFS_MERIT_B: begin
                    merit_b_r <= reg_wdata_i;
                end
                OFS_MERIT_C: begin
                    merit_c_r <= reg_wdata_i;
                end
                OFS_ALT_EN: begin
                    alt_merit_linear_o <= reg_wdata_i[BIT_ALT_LIN];
                    alt_merit_feedback_o <= reg_wdata_i[BIT_ALT_FB];
                end
                OFS_LOOK: begin
                    look_beyond_o <= reg_wdata_i[2:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ============================================================
    // Sticky loss flags
    // Set wins over the read clear so an event in the read cycle survives
    assign loss_rd = reg_rd_i && (reg_addr_i == OFS_LOSS);
    always_comb begin
        loss_nxt = loss_rd ? 2'b00 : loss_r;
        loss_nxt[BIT_LOCK_LOST] = loss_nxt[BIT_LOCK_LOST] | lock_lost_i;
        loss_nxt[BIT_SIG_LOST] = loss_nxt[BIT_SIG_LOST] | signal_lost_i;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            loss_r <= 2'b00;
        end else begin
            loss_r <= loss_nxt;
        end
    end

    // ============================================================
    // Read mux
    // Observation and tap fields are sampled live at the read strobe
    always_comb begin
        rdata_nxt = RST_ZERO;
        case (reg_addr_i)
            OFS_SIG_OBS: begin
                rdata_nxt[BIT_SIG_DET] = signal_detect_i;
                rdata_nxt[BIT_EQ_LIMIT] = eq_limiting_i;
                rdata_nxt[BIT_LOCK_IRQ] = lock_irq_i;
                rdata_nxt[BIT_SIGDET_IRQ] = sigdet_irq_i;
            end
            OFS_ALT_OBS: begin
                rdata_nxt[BIT_ALT_VIEW] = alt_view_i;
                rdata_nxt[BIT_LOW_DIV] = low_div_adapt_i;
            end
            OFS_LOSS: begin
                rdata_nxt[1:0] = loss_r;
            end
            OFS_G0_LO: rdata_nxt = cnt_lo_r[0];
            OFS_G0_HI: rdata_nxt = cnt_hi_r[0];
            OFS_G1_LO: rdata_nxt = cnt_lo_r[1];
            OFS_G1_HI: rdata_nxt = cnt_hi_r[1];
            OFS_DELTA: rdata_nxt = delta_r;
            OFS_MON_INT: rdata_nxt[3:0] = mon_int_r;
            OFS_EYE_THR: rdata_nxt = {vert_lock_thr_o, horiz_lock_thr_o};
            OFS_MERIT_A: rdata_nxt = merit_a_r;
            OFS_MERIT_B: rdata_nxt = merit_b_r;
            OFS_MERIT_C: rdata_nxt = merit_c_r;
            OFS_ALT_EN: begin
                rdata_nxt[BIT_ALT_LIN] = alt_merit_linear_o;
                rdata_nxt[BIT_ALT_FB] = alt_merit_feedback_o;
            end
            OFS_LOOK: rdata_nxt[2:0] = look_beyond_o;
            OFS_TAP1: begin
                rdata_nxt[BIT_TAP1_SIGN] = tap1_sign_i;
                rdata_nxt[4:0] = tap1_mag_i;
            end
            OFS_TAP2: begin
                rdata_nxt[BIT_TAP2_SIGN] = tap2_sign_i;
                rdata_nxt[3:0] = tap2_mag_i;
            end
            default: rdata_nxt = RST_ZERO;
        endcase
    end

    // Read data holds until the next read strobe
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            reg_rdata_o <= RST_ZERO;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rdata_nxt;
        end
    end

    // ============================================================
    // Lock monitoring interval
    // Counters restart whenever lock drops, so the first sample is a full N intervals out
    assign mon_run = lock_detectors_locked_i && monitor_enable_i;
    assign base_tick = (base_cnt_r == 18'(BASE_CYCLES - 1));

    always_ff @(posedge clk_i) begin
        if (reset_i || !mon_run) begin
            base_cnt_r <= '0;
        end else if (base_tick) begin
            base_cnt_r <= '0;
        end else begin
            base_cnt_r <= base_cnt_r + 18'd1;
        end
    end

    // A programmed count of zero behaves as one interval
    always_ff @(posedge clk_i) begin
        if (reset_i || !mon_run) begin
            ivl_cnt_r <= '0;
            eye_sample_o <= 1'b0;
        end else if (base_tick) begin
            if (ivl_cnt_r + 4'd1 >= mon_int_r) begin
                ivl_cnt_r <= '0;
                eye_sample_o <= 1'b1;
            end else begin
                ivl_cnt_r <= ivl_cnt_r + 4'd1;
                eye_sample_o <= 1'b0;
            end
        end else begin
            eye_sample_o <= 1'b0;
        end
    end

    // ============================================================
    // Adaptation merit
    rca_merit_calc u_merit (
        .horiz_i(horizontal_eye_opening_i),
        .vert_i(vertical_eye_opening_i),
        .weight_a_i(merit_a_r),
        .offset_b_i(merit_b_r),
        .offset_c_i(merit_c_r),
        .merit_o(merit_calc)
    );

    // Registered so the output comes straight from a flop
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            adaptation_merit_o <= '0;
        end else begin
            adaptation_merit_o <= merit_calc;
        end
    end

    // ============================================================
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    lock_loss_set_a: assert property (lock_lost_i |=> loss_r[BIT_LOCK_LOST])
        else $error("lock loss not latched");
    sig_loss_set_a: assert property (signal_lost_i |=> loss_r[BIT_SIG_LOST])
        else $error("signal loss not latched");
    loss_read_clear_a: assert property (
        (loss_rd && !lock_lost_i && !signal_lost_i) |=> (loss_r == 2'b00))
        else $error("loss flags not cleared by read");
    loss_hold_a: assert property (
        (!loss_rd && loss_r[BIT_SIG_LOST]) |=> loss_r[BIT_SIG_LOST])
        else $error("signal loss flag dropped without read");
    obs_detect_read_a: assert property (
        (reg_rd_i && reg_addr_i == OFS_SIG_OBS) |=>
        (reg_rdata_o[BIT_SIG_DET] == $past(signal_detect_i)))
        else $error("signal detect readback wrong");
    alt_view_read_a: assert property (
        (reg_rd_i && reg_addr_i == OFS_ALT_OBS) |=>
        (reg_rdata_o[BIT_ALT_VIEW] == $past(alt_view_i)))
        else $error("alternate view readback wrong");
    grp0_override_a: assert property (
        cnt_hi_r[0][BIT_OVERRIDE] |=>
        (grp_count_o[0] == {$past(cnt_hi_r[0][6:0]), $past(cnt_lo_r[0])}) &&
        (grp_delta_o[0] == $past(delta_r[7:4])))
        else $error("group zero override not applied");
    grp1_builtin_a: assert property (
        !cnt_hi_r[1][BIT_OVERRIDE] |=> (grp_count_o[1] == $past(grp_builtin_count_i[1])))
        else $error("group one built-in count not passed");
    look_write_a: assert property (
        (reg_wr_i && reg_addr_i == OFS_LOOK) |=> (look_beyond_o == $past(reg_wdata_i[2:0])))
        else $error("look-beyond write not taken");
    mon_gate_a: assert property (!mon_run |=> !eye_sample_o)
        else $error("eye sample while monitoring off");
    sample_pulse_a: assert property (eye_sample_o |=> !eye_sample_o [*2])
        else $error("eye sample not a single pulse");
    ro_write_a: assert property (
        (reg_wr_i && reg_addr_i == OFS_TAP1) |=> $stable(look_beyond_o) && $stable(merit_a_r))
        else $error("read-only write disturbed state");
endmodule
`default_nettype wire

/* logic/rca_pkg.sv */
// Purpose: Shared constants for the retimer channel adaptation/status register slice.
// Assumes: Byte-wide register port, one 8-bit register per printed offset.
// Notes: Timing constants assume the 25 MHz core clock.
`default_nettype none
package rca_pkg;
    // ============================================================
    // Register offsets
    localparam logic [7:0] OFS_SIG_OBS = 8'h54;
    localparam logic [7:0] OFS_ALT_OBS = 8'h55;
    localparam logic [7:0] OFS_LOSS = 8'h56;
    localparam logic [7:0] OFS_G0_LO = 8'h60;
    localparam logic [7:0] OFS_G0_HI = 8'h61;
    localparam logic [7:0] OFS_G1_LO = 8'h62;
    localparam logic [7:0] OFS_G1_HI = 8'h63;
    localparam logic [7:0] OFS_DELTA = 8'h64;
    localparam logic [7:0] OFS_MON_INT = 8'h69;
    localparam logic [7:0] OFS_EYE_THR = 8'h6A;
    localparam logic [7:0] OFS_MERIT_A = 8'h6B;
    localparam logic [7:0] OFS_MERIT_B = 8'h6C;
    localparam logic [7:0] OFS_MERIT_C = 8'h6D;
    localparam logic [7:0] OFS_ALT_EN = 8'h6E;
    localparam logic [7:0] OFS_LOOK = 8'h70;
    localparam logic [7:0] OFS_TAP1 = 8'h71;
    localparam logic [7:0] OFS_TAP2 = 8'h72;

    // ============================================================
    // Reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [3:0] RST_MON_INT = 4'hA;
    localparam logic [3:0] RST_EYE_THR = 4'h4;
    localparam logic [7:0] RST_MERIT_A = 8'h40;
    localparam logic [2:0] RST_LOOK = 3'h3;

    // ============================================================
    // Field positions
    localparam int BIT_SIG_DET = 7;
    localparam int BIT_EQ_LIMIT = 6;
    localparam int BIT_LOCK_IRQ = 1;
    localparam int BIT_SIGDET_IRQ = 0;
    localparam int BIT_ALT_VIEW = 4;
    localparam int BIT_LOW_DIV = 0;
    localparam int BIT_LOCK_LOST = 1;
    localparam int BIT_SIG_LOST = 0;
    localparam int BIT_OVERRIDE = 7;
    localparam int BIT_ALT_LIN = 7;
    localparam int BIT_ALT_FB = 6;
    localparam int BIT_TAP1_SIGN = 5;
    localparam int BIT_TAP2_SIGN = 4;
    localparam int NUM_GROUPS = 2;

    // ============================================================
    // Merit arithmetic
    localparam logic signed [9:0] MERIT_FULL = 10'sh080;
    localparam int MERIT_DIV = 127;

    // ============================================================
    // Lock monitoring timing
    localparam real CLK_MHZ = 25.0;
    localparam real BASE_INTERVAL_MS = 6.5;
    localparam int BASE_INTERVAL_CYC = int'(BASE_INTERVAL_MS * CLK_MHZ * 1000.0);
endpackage
`default_nettype wire

/* logic/rca_merit_calc.sv */
// Purpose: Combinational adaptation merit from eye openings and weight terms.
// Assumes: Openings and terms are unsigned bytes; result is signed.
// Notes: Caller registers the result; the divider by a constant costs area.
`timescale 1ns/1ps
`default_nettype none
module rca_merit_calc
    import rca_pkg::*;
(
    input wire logic [7:0] horiz_i,
    input wire logic [7:0] vert_i,
    input wire logic [7:0] weight_a_i,
    input wire logic [7:0] offset_b_i,
    input wire logic [7:0] offset_c_i,
    output logic signed [19:0] merit_o
);
    // ============================================================
    // Weighted terms
    logic signed [9:0] h_diff;
    logic signed [9:0] v_diff;
    logic signed [9:0] w_h;
    logic signed [9:0] w_v;
    logic signed [19:0] h_term;
    logic signed [19:0] v_term;

    // Differences go negative when the offset exceeds the opening
    always_comb begin
        h_diff = $signed({2'b00, horiz_i}) - $signed({2'b00, offset_b_i});
        v_diff = $signed({2'b00, vert_i}) - $signed({2'b00, offset_c_i});
        w_h = $signed({2'b00, weight_a_i});
        w_v = MERIT_FULL - w_h;
        h_term = (20'(h_diff) * 20'(w_h)) / 20'(MERIT_DIV);
        v_term = (20'(v_diff) * 20'(w_v)) / 20'(MERIT_DIV);
        merit_o = (h_term < v_term) ? h_term : v_term;
    end
endmodule
`default_nettype wire

/* bench/rca_regs_bench.sv */
// Purpose: Self-checking bench for the adaptation and status register slice.
// Assumes: Byte strobe port, read data visible one cycle after the read strobe.
// Notes: BASE_CYCLES is shrunk to 8 so the monitor interval is short.
`timescale 1ns/1ps
`default_nettype none
module rca_regs_bench;
    import rca_pkg::*;
    localparam int BASE = 8;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic wr = 1'b0, rd = 1'b0;
    logic sd = 1'b0, lim = 1'b0, lirq = 1'b0, sirq = 1'b0, altv = 1'b0, lowd = 1'b0;
    logic lock_lost = 1'b0, sig_lost = 1'b0, t1s = 1'b0, t2s = 1'b0;
    logic [4:0] t1m = 5'h00;
    logic [3:0] t2m = 4'h0;
    logic [1:0][14:0] bcnt = {15'h0456, 15'h0123};
    logic [1:0][3:0] bdel = {4'h9, 4'h7};
    logic locked = 1'b0, mon_en = 1'b0;
    logic [7:0] horizontal_eye_opening = 8'h00, vertical_eye_opening = 8'h00;
    logic [1:0][14:0] gcnt;
    logic [1:0][3:0] gdel;
    logic [1:0] gov;
    logic eye, alt_lin, alt_fb;
    logic [3:0] vthr, hthr;
    logic signed [19:0] merit;
    logic [2:0] look;
    int n_errors = 0;
    int samples_checked = 0;
    localparam logic [7:0] RA [0:16] = '{8'h54, 8'h55, 8'h56, 8'h60, 8'h61, 8'h62, 8'h63,
        8'h64, 8'h69, 8'h6A, 8'h6B, 8'h6C, 8'h6D, 8'h6E, 8'h70, 8'h71, 8'h72};
    localparam logic [7:0] RV [0:16] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h0A, 8'h44, 8'h40, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00};

    rca_regs #(.BASE_CYCLES(BASE)) dut (.clk_i(clk_i), .reset_i(reset_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .signal_detect_i(sd), .eq_limiting_i(lim),
        .lock_irq_i(lirq), .sigdet_irq_i(sirq), .alt_view_i(altv),
        .low_div_adapt_i(lowd), .lock_lost_i(lock_lost), .signal_lost_i(sig_lost),
        .tap1_sign_i(t1s), .tap1_mag_i(t1m), .tap2_sign_i(t2s), .tap2_mag_i(t2m),
        .grp_builtin_count_i(bcnt), .grp_builtin_delta_i(bdel),
        .lock_detectors_locked_i(locked), .monitor_enable_i(mon_en),
        .horizontal_eye_opening_i(horizontal_eye_opening), .vertical_eye_opening_i(vertical_eye_opening),
        .grp_count_o(gcnt), .grp_delta_o(gdel), .grp_override_o(gov),
        .eye_sample_o(eye), .vert_lock_thr_o(vthr), .horiz_lock_thr_o(hthr),
        .adaptation_merit_o(merit), .alt_merit_linear_o(alt_lin),
        .alt_merit_feedback_o(alt_fb), .look_beyond_o(look));

    // ============================================================
    // Clock and port tasks
    initial begin
        forever #20 clk_i = ~clk_i;
    end

    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Strobe stands for one edge, then one idle edge so it never toggles twice in a step
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        tick();
        wr = 1'b0;
        tick();
    endtask

    // Read data holds until the next read, so it is still valid after the idle edge
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        rd = 1'b1;
        tick();
        rd = 1'b0;
        tick();
        cmp($sformatf("reg %h", a), {24'h0, exp}, {24'h0, rdata});
    endtask

    // Gap in cycles between two sample pulses; zero pulses seen gives 0
    task automatic eye_gap(output int gap);
        int n;
        n = 0;
        gap = 0;
        for (int i = 0; i < 200 && gap == 0; i++) begin
            tick();
            if (eye === 1'b1) begin
                gap = (n > 0) ? i - n : 0;
                n = i;
            end
        end
    endtask

    function automatic int merit_exp(int h, int v, int a, int b, int c);
        int x;
        int y;
        x = (h - b) * a / 127;
        y = (v - c) * (128 - a) / 127;
        return (x < y) ? x : y;
    endfunction

    task automatic wrap_up();
        $display("checks=%0d errors=%0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Watchdog: the whole run needs well under 2000 cycles
    initial begin
        #200000;
        n_errors++;
        wrap_up();
    end

    // ============================================================
    // Test sequence
    initial begin
        int g;
        int m;
        logic [7:0] mh [0:2] = '{8'h50, 8'h05, 8'hC8};
        logic [7:0] mv [0:2] = '{8'h60, 8'hFF, 8'h30};
        logic [7:0] ma [0:2] = '{8'h40, 8'h7F, 8'h00};
        logic [7:0] mb [0:2] = '{8'h10, 8'h10, 8'h00};
        logic [7:0] mc [0:2] = '{8'h20, 8'h00, 8'h00};
        repeat (2) @(posedge clk_i);
        #1;
        reset_i = 1'b0;
        // Reset values of every register and of the threshold, look-beyond and merit-select outputs
        for (int i = 0; i < 17; i++) rd_chk(RA[i], RV[i]);
        cmp("thresholds", 32'h44, {24'h0, vthr, hthr});
        cmp("look", 32'h3, {29'h0, look});
        cmp("merit sel", 32'h0, {30'h0, alt_lin, alt_fb});
        // Live observation and tap readback, writes there ignored
        {sd, lim, lirq, sirq, altv, lowd} = 6'b111111;
        {t1s, t1m, t2s, t2m} = {1'b1, 5'h15, 1'b1, 4'hA};
        for (int i = 0; i < 3; i++) wr_reg(i == 0 ? 8'h54 : 8'h70 + 8'(i), 8'h00);
        wr_reg(8'h55, 8'h00);
        rd_chk(8'h54, 8'hC3);
        rd_chk(8'h55, 8'h11);
        rd_chk(8'h71, 8'h35);
        rd_chk(8'h72, 8'h1A);
        {sd, lirq, lowd, t1s, t2m} = {1'b0, 1'b0, 1'b0, 1'b0, 4'h5};
        rd_chk(8'h54, 8'h41);
        rd_chk(8'h55, 8'h10);
        rd_chk(8'h71, 8'h15);
        rd_chk(8'h72, 8'h15);
        // Sticky loss flags: latch on a one-cycle event, clear on read only
        lock_lost = 1'b1;
        tick();
        lock_lost = 1'b0;
        wr_reg(8'h56, 8'h00);
        repeat (3) tick();
        rd_chk(8'h56, 8'h02);
        rd_chk(8'h56, 8'h00);
        sig_lost = 1'b1;
        tick();
        sig_lost = 1'b0;
        rd_chk(8'h56, 8'h01);
        rd_chk(8'h56, 8'h00);
        // Event only in the read cycle: set must win over the clear
        sig_lost = 1'b1;
        addr = 8'h56;
        rd = 1'b1;
        tick();
        {sig_lost, rd} = 2'b00;
        tick();
        cmp("read and set", 32'h0, {24'h0, rdata});
        rd_chk(8'h56, 8'h01);
        rd_chk(8'h5A, 8'h00);
        // Tolerance groups: built-in until override, then programmed values
        wr_reg(8'h60, 8'h34);
        wr_reg(8'h61, 8'h12);
        wr_reg(8'h62, 8'hCD);
        wr_reg(8'h63, 8'h2B);
        wr_reg(8'h64, 8'h5A);
        tick();
        cmp("count", {2'b0, bcnt}, {2'b0, gcnt});
        cmp("delta", 32'h97, {24'h0, gdel});
        wr_reg(8'h61, 8'h92);
        tick();
        cmp("ovr0", {2'b0, 15'h0456, 15'h1234}, {2'b0, gcnt});
        cmp("dlt0", 32'h95, {24'h0, gdel});
        cmp("ov", 32'h1, {30'h0, gov});
        wr_reg(8'h63, 8'hAB);
        tick();
        cmp("ovr1", {2'b0, 15'h2BCD, 15'h1234}, {2'b0, gcnt});
        cmp("dlt1", 32'hA5, {24'h0, gdel});
        rd_chk(8'h61, 8'h92);
        rd_chk(8'h63, 8'hAB);
        // Threshold, alternate merit and look-beyond fields
        wr_reg(8'h6A, 8'h9C);
        wr_reg(8'h6E, 8'hC0);
        wr_reg(8'h70, 8'h07);
        cmp("thr", 32'h9C, {24'h0, vthr, hthr});
        cmp("alt", 32'h3, {30'h0, alt_lin, alt_fb});
        cmp("look7", 32'h7, {29'h0, look});
        wr_reg(8'h6E, 8'h40);
        wr_reg(8'h70, 8'h00);
        cmp("alt fb", 32'h1, {30'h0, alt_lin, alt_fb});
        cmp("look0", 32'h0, {29'h0, look});
        rd_chk(8'h6A, 8'h9C);
        // Merit over positive, negative and zero-weight cases
        for (int i = 0; i < 3; i++) begin
            wr_reg(8'h6B, ma[i]);
            wr_reg(8'h6C, mb[i]);
            wr_reg(8'h6D, mc[i]);
            horizontal_eye_opening = mh[i];
            vertical_eye_opening = mv[i];
            repeat (2) tick();
            m = merit_exp(mh[i], mv[i], ma[i], mb[i], mc[i]);
            cmp("merit", {12'h0, m[19:0]}, {12'h0, merit});
        end
        // Monitor pulses once every N base intervals while locked and enabled
        locked = 1'b1;
        wr_reg(8'h69, 8'h03);
        mon_en = 1'b1;
        eye_gap(g);
        cmp("gap3", 32'(3 * BASE), 32'(g));
        mon_en = 1'b0;
        wr_reg(8'h69, 8'h01);
        mon_en = 1'b1;
        eye_gap(g);
        cmp("gap1", 32'(BASE), 32'(g));
        mon_en = 1'b0;
        eye_gap(g);
        cmp("off", 32'h0, 32'(g));
        mon_en = 1'b1;
        locked = 1'b0;
        eye_gap(g);
        cmp("unlocked", 32'h0, 32'(g));
        wrap_up();
    end
endmodule
`default_nettype wire
